// ### rtl/cstc_pkg.sv
// Package for the clock source and trim control block
package cstc_pkg;

	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [1:0] MAIN_CLOCK_CONTROL_OFS = 2'h0;
	localparam logic [1:0] RC_OSCILLATOR_TRIM_OFS = 2'h1;
	localparam logic [1:0] LOCK_STATUS_OFS        = 2'h2;
	localparam logic [1:0] FACTORY_TRIM_OFS       = 2'h3;
	localparam int         SMS_BIT                = 0;
	localparam int         MCO_BIT                = 1;
	localparam logic [7:0] MCC_RESET              = 8'h00;
	localparam logic [7:0] MCC_WRITE_MASK         = 8'h03;
	localparam logic [7:0] RC_TRIM_RESET          = 8'hff;
	localparam logic [7:0] RC_TRIM_SEARCH_START   = 8'h80;
	localparam logic [7:0] FACTORY_ERASED         = 8'hff;

	// ****************************************
	// Clock figures and timing
	// ****************************************
	localparam int         CORE_CLK_MHZ           = 40;
	localparam int         SLOW_DIVIDE            = 32;
	localparam int         PLL_MUL_LOW            = 4;
	localparam int         PLL_MUL_HIGH           = 8;
	localparam int         TIMER_PLL_MUL          = 4;
	localparam int         PLL_STARTUP_US         = 1;
	localparam int         PLL_STARTUP_CYC        = (PLL_STARTUP_US * CORE_CLK_MHZ > 0) ?
	                                                 PLL_STARTUP_US * CORE_CLK_MHZ : 1;
	localparam int         PLL_LOCK_EXTRA_CYC     = 8;

	// ****************************************
	// Option-bit encodings
	// ****************************************
	typedef enum logic [2:0] {
		CSTC_SRC_EXT, CSTC_SRC_XTAL_LP, CSTC_SRC_XTAL_1, CSTC_SRC_XTAL_2,
		CSTC_SRC_XTAL_3, CSTC_SRC_XTAL_4, CSTC_SRC_RC, CSTC_SRC_EXT_PB4
	} cstc_src_t;

	typedef enum logic [1:0] {
		CSTC_PLL_OFF, CSTC_PLL_X4, CSTC_PLL_X8, CSTC_PLL_RSVD
	} cstc_pll_t;

	typedef struct packed {
		cstc_src_t  source;
		cstc_pll_t  pll_mode;
		logic       timer_pll_en;
		logic       ext_halve;
	} cstc_opt_t;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cstc_bus_t;

endpackage

// ### rtl/cstc_top.sv
// Clock source selection, PLL control, slow mode, clock out and RC trim
//
// The implementer's own choices: the register addresses and the strobed register port.
module cstc_top
	import cstc_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  cstc_bus_t       bus,
	output logic [7:0]      rdata,
	input  cstc_opt_t       opt_bits,
	input  wire logic       wakeup,
	input  wire logic       readout_prot,
	input  wire logic [7:0] factory_5v_init,
	input  wire logic [7:0] factory_3v_init,
	output logic [7:0]      rc_trim_value,
	output logic            rc_osc_en,
	output logic            xtal_osc_en,
	output cstc_src_t       active_source,
	output logic            ext_from_port_b_line_4,
	output logic [3:0]      pll_factor,
	output logic            pll_run,
	output logic            osc_clk_gate,
	output logic            pll_locked,
	output logic            slow_mode_select,
	output logic            main_clock_output_enable,
	output logic            timer_pll_run,
	output logic            timer_input_ok
);

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] mcc_r, mcc_nxt;
	logic [7:0] trim_r, trim_nxt;
	logic [7:0] fac5_r, fac3_r;
	logic       fac_loaded_r;
	logic       prot_s1_r, prot_s2_r, prot_old_r;
	logic       wake_s1_r, wake_s2_r;
	cstc_opt_t  opt_r;
	logic       opt_loaded_r;
	logic [15:0] start_cnt_r;
	logic [3:0] lock_cnt_r;
	logic       gate_r, lock_r;
	logic [7:0] rdata_r;

	// Decode of the plain register port
	function automatic logic hit(input logic [1:0] a, input logic [1:0] ofs);
		hit = (a == ofs);
	endfunction

	wire wr_mcc  = bus.wr && hit(bus.addr, MAIN_CLOCK_CONTROL_OFS);
	wire wr_trim = bus.wr && hit(bus.addr, RC_OSCILLATOR_TRIM_OFS);
	wire pll_on  = (opt_r.pll_mode == CSTC_PLL_X4) || (opt_r.pll_mode == CSTC_PLL_X8);
	wire erase   = prot_old_r && !prot_s2_r;
	// Restart on reset release or on wakeup from halt
	wire restart = !opt_loaded_r || wake_s2_r;

	// Reserved bits forced to zero on write
	assign mcc_nxt  = wr_mcc ? (bus.wdata & MCC_WRITE_MASK) : mcc_r;
	assign trim_nxt = wr_trim ? bus.wdata : trim_r;

	// ****************************************
	// Software registers
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			mcc_r  <= MCC_RESET;
			trim_r <= RC_TRIM_RESET;
		end
		else
		begin
			mcc_r  <= mcc_nxt;
			trim_r <= trim_nxt;
		end
	end

	// Factory trim copies reload from the init inputs after each reset; erased by protection removal
	always_ff @(posedge core_clk)
	begin
		if (!fac_loaded_r || erase)
		begin
			fac5_r <= erase ? FACTORY_ERASED : factory_5v_init;
			fac3_r <= erase ? FACTORY_ERASED : factory_3v_init;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			fac_loaded_r <= 1'b0;
		else
			fac_loaded_r <= 1'b1;
	end

	// Two-stage synchronisers for pin-side levels
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			prot_s1_r  <= 1'b0;
			prot_s2_r  <= 1'b0;
			prot_old_r <= 1'b0;
			wake_s1_r  <= 1'b0;
			wake_s2_r  <= 1'b0;
		end
		else
		begin
			prot_s1_r  <= readout_prot;
			prot_s2_r  <= prot_s1_r;
			prot_old_r <= prot_s2_r;
			wake_s1_r  <= wakeup;
			wake_s2_r  <= wake_s1_r;
		end
	end

	// ****************************************
	// Option capture
	// ****************************************
	// Options are caught on the first clock after reset release and then frozen,
	// so a glitch on the option lines cannot switch clocks mid-run.
	always_ff @(posedge core_clk)
	begin
		if (rst)
			opt_loaded_r <= 1'b0;
		else
			opt_loaded_r <= 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!opt_loaded_r && !rst)
			opt_r <= opt_bits;
	end

	// ****************************************
	// PLL startup and lock
	// ****************************************
	// Output held off for the startup delay, lock after a few more cycles
	always_ff @(posedge core_clk)
	begin
		if (rst || restart)
		begin
			start_cnt_r <= 16'h0000;
			lock_cnt_r  <= 4'h0;
			gate_r      <= 1'b0;
			lock_r      <= 1'b0;
		end
		else if (!pll_on)
		begin
			gate_r <= 1'b1;
			lock_r <= 1'b0;
		end
		else if (start_cnt_r < 16'(PLL_STARTUP_CYC - 1))
			start_cnt_r <= start_cnt_r + 16'h0001;
		else if (!gate_r)
			gate_r <= 1'b1;
		else if (lock_cnt_r < 4'(PLL_LOCK_EXTRA_CYC - 1))
			lock_cnt_r <= lock_cnt_r + 4'h1;
		else
			lock_r <= 1'b1;
	end

	// ****************************************
	// Read path and outputs
	// ****************************************
	wire [7:0] rd_mux =
		hit(bus.addr, MAIN_CLOCK_CONTROL_OFS) ? mcc_r :
		hit(bus.addr, RC_OSCILLATOR_TRIM_OFS) ? trim_r :
		hit(bus.addr, LOCK_STATUS_OFS)        ? {7'h00, lock_r} :
		fac5_r;
	wire rc_sel   = (opt_r.source == CSTC_SRC_RC);
	wire xtal_sel = (opt_r.source != CSTC_SRC_EXT) && !rc_sel &&
	                (opt_r.source != CSTC_SRC_EXT_PB4);
	// 8 MHz reaches the timer PLL by RC x8, or external halved (x8 if 2 MHz)
	wire t_ok = opt_r.timer_pll_en &&
	            ((rc_sel && opt_r.pll_mode == CSTC_PLL_X8) || opt_r.ext_halve);

	always_ff @(posedge core_clk)
	begin
		if (rst)
			rdata_r <= 8'h00;
		else
			rdata_r <= bus.rd ? rd_mux : 8'h00;
	end

	// Registered status and clock-tree controls
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rc_osc_en     <= 1'b0;
			active_source <= CSTC_SRC_EXT;
			ext_from_port_b_line_4 <= 1'b0;
			pll_factor    <= 4'h1;
			pll_run       <= 1'b0;
			timer_pll_run <= 1'b0;
			timer_input_ok <= 1'b0;
		end
		else
		begin
			rc_osc_en     <= rc_sel;
			active_source <= opt_r.source;
			ext_from_port_b_line_4 <= (opt_r.source == CSTC_SRC_EXT_PB4);
			// Unity factor gives raw RC or raw external clock
			pll_factor    <= (opt_r.pll_mode == CSTC_PLL_X8) ? 4'(PLL_MUL_HIGH) :
			                 (opt_r.pll_mode == CSTC_PLL_X4) ? 4'(PLL_MUL_LOW) :
			                 4'h1;
			pll_run       <= pll_on;
			timer_pll_run <= t_ok;
			timer_input_ok <= t_ok;
		end
	end

	// Crystal enable is never dropped by reset, so no restart time is paid
	always_ff @(posedge core_clk)
	begin
		xtal_osc_en <= opt_loaded_r ? xtal_sel : xtal_osc_en;
	end

	assign rdata                    = rdata_r;
	assign rc_trim_value            = trim_r;
	assign osc_clk_gate             = gate_r;
	assign pll_locked               = lock_r;
	assign slow_mode_select         = mcc_r[SMS_BIT];
	assign main_clock_output_enable = mcc_r[MCO_BIT];

	// ****************************************
	// Checks
	// ****************************************
	sequence s_restart;
		!rst && restart;
	endsequence

	a_trim_reset_value: assert property (@(posedge core_clk) rst |=> trim_r == RC_TRIM_RESET)
		else $error("trim not all ones after reset");
	a_mcc_reset_zero: assert property (@(posedge core_clk) rst |=> mcc_r == MCC_RESET)
		else $error("main clock control not zero after reset");
	a_mcc_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
		mcc_r[7:2] == 6'h00)
		else $error("reserved bits set");
	a_trim_write_lands: assert property (@(posedge core_clk) disable iff (rst)
		wr_trim |=> trim_r == $past(bus.wdata))
		else $error("trim write lost");
	a_pll_gate_held: assert property (@(posedge core_clk) disable iff (rst)
		s_restart ##1 pll_on |-> !gate_r)
		else $error("pll output not held off");
	a_lock_after_gate: assert property (@(posedge core_clk) disable iff (rst)
		$rose(lock_r) |-> gate_r && pll_on)
		else $error("lock before output");
	a_slow_out: assert property (@(posedge core_clk) disable iff (rst)
		wr_mcc |=> slow_mode_select == $past(bus.wdata[SMS_BIT]))
		else $error("slow mode bit mismatch");
	a_mco_out: assert property (@(posedge core_clk) disable iff (rst)
		wr_mcc |=> main_clock_output_enable == $past(bus.wdata[MCO_BIT]))
		else $error("clock out bit mismatch");
	a_opt_frozen: assert property (@(posedge core_clk) disable iff (rst || !opt_loaded_r)
		opt_loaded_r && $past(opt_loaded_r) |-> $stable(opt_r))
		else $error("options changed while running");
	a_erase_fac: assert property (@(posedge core_clk) erase |=> fac5_r == FACTORY_ERASED)
		else $error("factory trim not erased");
	a_erase_fac3: assert property (@(posedge core_clk) erase |=> fac3_r == FACTORY_ERASED)
		else $error("factory 3 V trim not erased");

	// ****************************************
	// Checks on the PLL startup sequence
	// ****************************************
	// Idle: no PLL chosen and nothing restarting
	sequence s_pll_idle;
		!rst && !restart && !pll_on;
	endsequence

	// Last startup count with the output still shut
	sequence s_gate_opens;
		!rst && !restart && pll_on && !gate_r &&
		(start_cnt_r == 16'(PLL_STARTUP_CYC - 1));
	endsequence

	// Last settling count while the output already runs
	sequence s_lock_due;
		!rst && !restart && pll_on && gate_r && !lock_r &&
		(lock_cnt_r == 4'(PLL_LOCK_EXTRA_CYC - 1));
	endsequence

	// A restart drops both the output and the lock flag
	a_restart_clears: assert property (@(posedge core_clk) disable iff (rst)
		s_restart |=> !gate_r && !lock_r)
		else $error("restart left pll output or lock up");

	// Without a PLL the oscillator clock passes straight on, never locked
	a_bypass_open: assert property (@(posedge core_clk) disable iff (rst)
		s_pll_idle |=> gate_r && !lock_r)
		else $error("bypass clock not passed on");

	// Output opens on the edge after the last startup count
	a_gate_opens: assert property (@(posedge core_clk) disable iff (rst)
		s_gate_opens |=> gate_r)
		else $error("pll output did not open");

	// Output never opens before the full startup count, so no runt clocks escape
	a_gate_not_early: assert property (@(posedge core_clk) disable iff (rst)
		$rose(gate_r) && pll_on |-> $past(start_cnt_r) == 16'(PLL_STARTUP_CYC - 1))
		else $error("pll output opened early");

	// Lock follows the settling count
	a_lock_due: assert property (@(posedge core_clk) disable iff (rst)
		s_lock_due |=> lock_r)
		else $error("lock flag not set");

	// Once set, lock holds until a restart
	a_lock_held: assert property (@(posedge core_clk) disable iff (rst)
		lock_r && !restart |=> lock_r)
		else $error("lock flag dropped without restart");

	// ****************************************
	// Checks on options, registers and reads
	// ****************************************
	// Crystal enable follows the frozen option, reset or not
	a_xtal_follows: assert property (@(posedge core_clk) opt_loaded_r |=>
		xtal_osc_en == $past(xtal_sel))
		else $error("crystal enable lost");

	// Multiplier shown matches the frozen PLL option
	a_factor_x8: assert property (@(posedge core_clk) disable iff (rst)
		opt_r.pll_mode == CSTC_PLL_X8 |=> pll_factor == 4'(PLL_MUL_HIGH))
		else $error("x8 factor not shown");
	a_factor_x4: assert property (@(posedge core_clk) disable iff (rst)
		opt_r.pll_mode == CSTC_PLL_X4 |=> pll_factor == 4'(PLL_MUL_LOW))
		else $error("x4 factor not shown");

	// Timer PLL stays off unless its option enables it
	a_timer_off: assert property (@(posedge core_clk) disable iff (rst)
		!opt_r.timer_pll_en |=> !timer_pll_run)
		else $error("timer pll ran without option");

	// Read data are zero except in the cycle after a read strobe
	a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
		!bus.rd |=> rdata_r == 8'h00)
		else $error("read data outside read cycle");

	// A trim read returns the register as it stood at the strobe
	a_trim_read: assert property (@(posedge core_clk) disable iff (rst)
		bus.rd && hit(bus.addr, RC_OSCILLATOR_TRIM_OFS) |=>
		rdata_r == $past(trim_r))
		else $error("trim read mismatch");

endmodule

// ### bench/testbench.sv
// Self-checking bench for the clock source and trim control block
module testbench
	import cstc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	cstc_bus_t bus = '0;
	cstc_opt_t opt_bits = '{CSTC_SRC_RC, CSTC_PLL_X8, 1'b1, 1'b0};
	logic wakeup = 1'b0;
	logic readout_prot = 1'b1;
	logic [7:0] factory_5v_init = 8'h5a;
	logic [7:0] factory_3v_init = 8'h3c;
	logic [7:0] rdata, rc_trim_value;
	logic [3:0] pll_factor;
	logic rc_osc_en, xtal_osc_en, ext_from_port_b_line_4, pll_run, osc_clk_gate;
	logic pll_locked, slow_mode_select, main_clock_output_enable;
	logic timer_pll_run, timer_input_ok;
	cstc_src_t active_source;
	int n_errors = 0;
	int n_compared = 0;
	int n;

	cstc_top i_dut (.core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata),
		.opt_bits(opt_bits), .wakeup(wakeup), .readout_prot(readout_prot),
		.factory_5v_init(factory_5v_init), .factory_3v_init(factory_3v_init),
		.rc_trim_value(rc_trim_value), .rc_osc_en(rc_osc_en), .xtal_osc_en(xtal_osc_en),
		.active_source(active_source), .ext_from_port_b_line_4(ext_from_port_b_line_4),
		.pll_factor(pll_factor), .pll_run(pll_run), .osc_clk_gate(osc_clk_gate),
		.pll_locked(pll_locked), .slow_mode_select(slow_mode_select),
		.main_clock_output_enable(main_clock_output_enable),
		.timer_pll_run(timer_pll_run), .timer_input_ok(timer_input_ok));

	// 40 MHz core clock
	initial
	begin
		forever #12.5 core_clk = ~core_clk;
	end

	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Strobe lasts one cycle, then the bus goes idle
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus <= '0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus <= '0;
		#1 chk(rdata, exp);
	endtask

	// Options change only while reset is held, as the hardware samples them once
	task automatic do_reset(input cstc_opt_t o);
		@(posedge core_clk);
		rst <= 1'b1;
		opt_bits <= o;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	// Counts cycles until the gate rises, bounded so a dead PLL cannot hang
	task automatic wait_gate();
		n = 0;
		while (osc_clk_gate !== 1'b1 && n < 200)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
	endtask

	task automatic summarize();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Run takes under two hundred cycles; allow ample margin
	initial
	begin
		#(20000 * 25);
		n_errors++;
		summarize();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		repeat (2) @(posedge core_clk);
		do_reset('{CSTC_SRC_RC, CSTC_PLL_X8, 1'b1, 1'b0});
		rd_chk(MAIN_CLOCK_CONTROL_OFS, MCC_RESET);
		rd_chk(RC_OSCILLATOR_TRIM_OFS, RC_TRIM_RESET);
		chk(rc_trim_value, 8'hff);
		chk({4'h0, pll_factor}, 8'h08);
		chk({7'h0, rc_osc_en}, 8'h01);
		chk({7'h0, timer_pll_run}, 8'h01);
		chk({7'h0, timer_input_ok}, 8'h01);
		chk({7'h0, pll_run}, 8'h01);
		chk({7'h0, xtal_osc_en}, 8'h00);
		chk({7'h0, osc_clk_gate}, 8'h00);
		wait_gate();
		chk((n > PLL_STARTUP_CYC - 8 && n < PLL_STARTUP_CYC + 3) ? 8'h01 : 8'h00, 8'h01);
		repeat (PLL_LOCK_EXTRA_CYC + 2) @(posedge core_clk);
		#1 chk({7'h0, pll_locked}, 8'h01);
		rd_chk(LOCK_STATUS_OFS, 8'h01);
		// Reserved bits must read back as zero
		wr(MAIN_CLOCK_CONTROL_OFS, 8'hff);
		rd_chk(MAIN_CLOCK_CONTROL_OFS, MCC_WRITE_MASK);
		chk({6'h0, main_clock_output_enable, slow_mode_select}, 8'h03);
		wr(MAIN_CLOCK_CONTROL_OFS, 8'h02);
		#1 chk({7'h0, slow_mode_select}, 8'h00);
		wr(RC_OSCILLATOR_TRIM_OFS, RC_TRIM_SEARCH_START);
		rd_chk(RC_OSCILLATOR_TRIM_OFS, 8'h80);
		wr(RC_OSCILLATOR_TRIM_OFS, 8'h00);
		#1 chk(rc_trim_value, 8'h00);
		rd_chk(FACTORY_TRIM_OFS, 8'h5a);
		wr(FACTORY_TRIM_OFS, 8'h11);
		rd_chk(FACTORY_TRIM_OFS, 8'h5a);
		// Options moved while running must not be taken
		opt_bits <= '{CSTC_SRC_EXT, CSTC_PLL_X4, 1'b0, 1'b0};
		repeat (3) @(posedge core_clk);
		chk({4'h0, pll_factor}, 8'h08);
		// Wakeup restarts the PLL and drops the lock
		wakeup <= 1'b1;
		repeat (6) @(posedge core_clk);
		wakeup <= 1'b0;
		#1 chk({7'h0, pll_locked}, 8'h00);
		repeat (PLL_STARTUP_CYC + PLL_LOCK_EXTRA_CYC + 8) @(posedge core_clk);
		#1 chk({7'h0, pll_locked}, 8'h01);
		// Protection cleared after being set wipes factory bytes
		readout_prot <= 1'b0;
		repeat (6) @(posedge core_clk);
		rd_chk(FACTORY_TRIM_OFS, FACTORY_ERASED);
		// Second reset discards calibration and register bits
		do_reset('{CSTC_SRC_EXT, CSTC_PLL_OFF, 1'b0, 1'b0});
		rd_chk(RC_OSCILLATOR_TRIM_OFS, RC_TRIM_RESET);
		rd_chk(MAIN_CLOCK_CONTROL_OFS, MCC_RESET);
		chk({7'h0, main_clock_output_enable}, 8'h00);
		chk({7'h0, rc_osc_en}, 8'h00);
		chk({7'h0, osc_clk_gate}, 8'h01);
		chk({7'h0, pll_locked}, 8'h00);
		chk({7'h0, timer_pll_run}, 8'h00);
		chk({5'h0, active_source}, 8'h00);
		wr(RC_OSCILLATOR_TRIM_OFS, 8'h5a);
		#1 chk(rc_trim_value, 8'h5a);
		do_reset('{CSTC_SRC_XTAL_2, CSTC_PLL_OFF, 1'b0, 1'b0});
		chk({7'h0, xtal_osc_en}, 8'h01);
		chk({5'h0, active_source}, 8'h03);
		// Crystal must keep running while reset is held
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1 chk({7'h0, xtal_osc_en}, 8'h01);
		do_reset('{CSTC_SRC_EXT_PB4, CSTC_PLL_X4, 1'b0, 1'b0});
		chk({7'h0, ext_from_port_b_line_4}, 8'h01);
		chk({4'h0, pll_factor}, 8'h04);
		summarize();
	end
endmodule
